/* File: hw/srbg_map.vh */
// Register map, field positions and reset values of the serial rate generator
`ifndef SRBG_MAP_VH
`define SRBG_MAP_VH
// ==========================================================
// Word offsets (byte address = 4 * index)
`define SRBG_IDX_BAUD_CONTROL   3'h0
`define SRBG_IDX_RECEIVE_STATUS 3'h1
`define SRBG_IDX_DIVISOR_LOW    3'h2
`define SRBG_IDX_DIVISOR_HIGH   3'h3
`define SRBG_IDX_TRANSMIT_STAT  3'h4
// ==========================================================
// Field positions
`define SRBG_BIT_RX_IDLE        6
`define SRBG_BIT_WIDE_SEL       3
`define SRBG_BIT_SYNC_MODE      4
`define SRBG_BIT_HIGH_SPEED     2
// ==========================================================
// Reset values
`define SRBG_RST_BYTE           8'h00
`define SRBG_RST_BAUD_CONTROL   8'h40
// ==========================================================
// Prescale counts
`define SRBG_PRE_SLOW           6'h3F
`define SRBG_PRE_MID            6'h0F
`define SRBG_PRE_FAST           6'h03
`endif

/* File: hw/srbg_rate_gen.v */
// Programmable baud rate generator with an Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "srbg_map.vh"

module srbg_rate_gen #(
    parameter ADDR_W = 3
) (
    input  wire              clk,
    input  wire              reset,
    input  wire [ADDR_W-1:0] avs_address,
    input  wire              avs_read,
    input  wire              avs_write,
    input  wire [31:0]       avs_writedata,
    output reg  [31:0]       avs_readdata,
    output wire              avs_waitrequest,
    input  wire              receive_idle_flag,
    output reg               rate_tick,
    output reg               timer_tick
);

    // ==========================================================
    // Register file
    // Control and divisor bytes; receive status is plain storage, transmit status bits 4 and 2 select sync and high speed
    reg  [7:0]  baud_control_q;
    reg  [7:0]  receive_status_control_q;
    reg  [7:0]  divisor_low_byte_q;
    reg  [7:0]  divisor_high_byte_q;
    reg  [7:0]  transmit_status_control_q;
    reg         ack_q;
    reg  [15:0] timer_q;
    reg  [5:0]  pre_q;
    reg  [2:0]  idle_sync_q;

    wire wide_counter_select = baud_control_q[`SRBG_BIT_WIDE_SEL];
    wire high_speed_select   = transmit_status_control_q[`SRBG_BIT_HIGH_SPEED];
    wire sync_mode           = transmit_status_control_q[`SRBG_BIT_SYNC_MODE];
    wire access              = (avs_read | avs_write) & ~ack_q;
    wire wr_en               = avs_write & ack_q;
    wire divisor_write       = wr_en & ((avs_address == `SRBG_IDX_DIVISOR_LOW) |
                                        (avs_address == `SRBG_IDX_DIVISOR_HIGH));

    // One wait state on every access; answer at the second edge
    // Costs a cycle per access but lets read data come from a flop
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;


    // Acknowledge flop, cleared after each completed access
    // Falls after one cycle, so back-to-back requests each get a wait state
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    // Writes land on the edge where waitrequest is low
    // Only the answer edge writes, so a held request lands exactly once
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            baud_control_q            <= `SRBG_RST_BYTE;
            receive_status_control_q  <= `SRBG_RST_BYTE;
            divisor_low_byte_q        <= `SRBG_RST_BYTE;
            divisor_high_byte_q       <= `SRBG_RST_BYTE;
            transmit_status_control_q <= `SRBG_RST_BYTE;
        end else if (wr_en) begin
            case (avs_address)
                `SRBG_IDX_BAUD_CONTROL: begin
                    // Only implemented control bits keep a value
                    baud_control_q <= avs_writedata[7:0] & 8'h1B;
                end
                `SRBG_IDX_RECEIVE_STATUS: begin
                    receive_status_control_q <= avs_writedata[7:0];
                end
                `SRBG_IDX_DIVISOR_LOW: begin
                    divisor_low_byte_q <= avs_writedata[7:0];
                end
                `SRBG_IDX_DIVISOR_HIGH: begin
                    divisor_high_byte_q <= avs_writedata[7:0];
                end
                `SRBG_IDX_TRANSMIT_STAT: begin
                    transmit_status_control_q <= avs_writedata[7:0];
                end
                default: begin
                    // Unmapped words swallow the write
                end
            endcase
        end
    end


    // Idle flag comes from the receiver pin domain: three-flop filter
    // Reset to idle so no false busy shows right after reset
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            idle_sync_q <= 3'h7;
        end else begin
            idle_sync_q <= {idle_sync_q[1:0], receive_idle_flag};
        end
    end

    reg idle_q;
    // Change accepted once second and third stages agree
    // A one-cycle glitch in the first stage never reaches software
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            idle_q <= 1'b1;
        end else if (idle_sync_q[1] == idle_sync_q[2]) begin
            idle_q <= idle_sync_q[2];
        end
    end


    // Read mux; unmapped words read as zero
    // Loaded at the first edge so the data stands through the answer cycle
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            avs_readdata <= 32'h00000000;
        end else if (access & avs_read) begin
            case (avs_address)
                `SRBG_IDX_BAUD_CONTROL: begin
                    // Bit 6 is live idle status, not a stored bit
                    avs_readdata <= {24'h000000, baud_control_q[7], idle_q,
                                     baud_control_q[5:0]};
                end
                `SRBG_IDX_RECEIVE_STATUS: begin
                    avs_readdata <= {24'h000000, receive_status_control_q};
                end
                `SRBG_IDX_DIVISOR_LOW: begin
                    avs_readdata <= {24'h000000, divisor_low_byte_q};
                end
                `SRBG_IDX_DIVISOR_HIGH: begin
                    avs_readdata <= {24'h000000, divisor_high_byte_q};
                end
                `SRBG_IDX_TRANSMIT_STAT: begin
                    avs_readdata <= {24'h000000, transmit_status_control_q};
                end
                default: begin
                    avs_readdata <= 32'h00000000;
                end
            endcase
        end
    end

    // ==========================================================
    // Rate timer
    // Counts 0 up to the reload and wraps, so a period is reload plus one
    // Compare with >= so a reload lowered below the count wraps at once
    // instead of running round all 65536 values first

    wire [15:0] divisor_n = {divisor_high_byte_q, divisor_low_byte_q};
    // Width select; high byte ignored in 8-bit mode
    wire [15:0] reload = wide_counter_select ? divisor_n : {8'h00, divisor_low_byte_q};
    wire        wrap   = (timer_q >= reload);

    // Free-running up counter, period n+1
    // Write clear wins over the wrap so the new rate starts from zero
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            timer_q    <= 16'h0000;
            timer_tick <= 1'b0;
        end else if (divisor_write) begin
            timer_q    <= 16'h0000;
            timer_tick <= 1'b0;
        end else begin
            timer_q    <= wrap ? 16'h0000 : timer_q + 16'h0001;
            timer_tick <= wrap;
        end
    end

    // ==========================================================
    // Prescaler
    reg [5:0] pre_limit;
    // Limit is the multiplier minus one: 63, 15 or 3 timer periods
    // Sync mode forces the fastest multiplier whatever high speed says
    // Multiplier 64, 16 or 4 from mode bits
    always @* begin
        if (sync_mode | (wide_counter_select & high_speed_select)) begin
            pre_limit = `SRBG_PRE_FAST;
        end else if (wide_counter_select | high_speed_select) begin
            pre_limit = `SRBG_PRE_MID;
        end else begin
            pre_limit = `SRBG_PRE_SLOW;
        end
    end


    // Moves only on timer wraps, so the whole chain is one enable pulse
    // A limit lowered under the count ends the period at the next wrap
    // Timer wrap divided by the prescale count (the prescaler gives the 64x, 16x or 4x of the timer period)
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_q     <= 6'h00;
            rate_tick <= 1'b0;
        end else if (divisor_write) begin
            pre_q     <= 6'h00;
            rate_tick <= 1'b0;
        end else begin
            rate_tick <= 1'b0;
            if (wrap) begin
                if (pre_q >= pre_limit) begin
                    pre_q     <= 6'h00;
                    rate_tick <= 1'b1;
                end else begin
                    pre_q <= pre_q + 6'h01;
                end
            end
        end
    end

endmodule // srbg_rate_gen
`default_nettype wire

/* File: sim/srbg_rate_gen_properties.sv */
// Port checker for the serial rate generator
`timescale 1ns/1ps
`default_nettype none
module srbg_rate_gen_properties (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [2:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        receive_idle_flag,
    input wire logic        rate_tick,
    input wire logic        timer_tick
);
    // ==========
    // Shadow config; periods trusted only two ticks after a write
    logic [7:0]  lo_q, hi_q, bc_q, tx_q;
    logic [23:0] rc_q, tc_q;
    logic [1:0]  rv_q, tv_q;
    wire         wr = avs_write && !avs_waitrequest;
    wire         rd = avs_read && !avs_waitrequest;
    wire [15:0]  n = bc_q[3] ? {hi_q, lo_q} : {8'h00, lo_q};
    wire [6:0]   m = (tx_q[4] | (bc_q[3] & tx_q[2])) ? 7'h04 : (bc_q[3] | tx_q[2]) ? 7'h10 : 7'h40;
    wire [23:0]  p = m * ({8'h00, n} + 24'h1);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {lo_q, hi_q, bc_q, tx_q, rc_q, tc_q, rv_q, tv_q} <= '0;
        end else begin
            if (wr && avs_address == 3'h2) lo_q <= avs_writedata[7:0];
            if (wr && avs_address == 3'h3) hi_q <= avs_writedata[7:0];
            if (wr && avs_address == 3'h0) bc_q <= avs_writedata[7:0];
            if (wr && avs_address == 3'h4) tx_q <= avs_writedata[7:0];
            rc_q <= rate_tick ? 24'h0 : rc_q + 24'h1;
            tc_q <= timer_tick ? 24'h0 : tc_q + 24'h1;
            rv_q <= wr ? 2'h0 : rv_q + {1'b0, rate_tick && rv_q != 2'h2};
            tv_q <= wr ? 2'h0 : tv_q + {1'b0, timer_tick && tv_q != 2'h2};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait state");
    wait_one_a: assert property (avs_waitrequest |=> !avs_waitrequest) else $error("long wait");
    rdata_hi_a: assert property (rd |-> avs_readdata[31:8] == 24'h0) else $error("upper bits");
    unmap_zero_a: assert property (rd && avs_address > 3'h4 |-> avs_readdata == 32'h0)
        else $error("unmapped read");
    div_read_a: assert property (rd && avs_address == 3'h2 |-> avs_readdata[7:0] == lo_q)
        else $error("divisor readback");
    rate_period_a: assert property (rate_tick && rv_q != 2'h0 |-> rc_q == p - 24'h1)
        else $error("rate period");
    timer_period_a: assert property (timer_tick && tv_q != 2'h0 |-> tc_q == {8'h00, n})
        else $error("timer period");
    tick_pulse_a: assert property (rate_tick |=> !rate_tick) else $error("tick width");
    cover property (wr && avs_address == 3'h3);
    cover property (rate_tick && rv_q != 2'h0 && m == 7'h04);
    cover property (rate_tick && rv_q != 2'h0 && m == 7'h40);
endmodule // srbg_rate_gen_properties
bind srbg_rate_gen srbg_rate_gen_properties i_chk (.*);
`default_nettype wire

/* File: sim/srbg_rate_gen_tb.sv */
// Self-checking bench for the serial rate generator
`timescale 1ns/1ps
`default_nettype none
module srbg_rate_gen_tb;
    logic        clk = 0, reset = 1, avs_read = 0, avs_write = 0, receive_idle_flag = 1;
    logic [2:0]  avs_address = 3'h0;
    logic [31:0] avs_writedata = 32'h0, q;
    logic [7:0]  hi, lo;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, rate_tick, timer_tick;
    int          errors = 0, cmp_count = 0, cyc = 0, c, p;
    srbg_rate_gen i_dut (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .receive_idle_flag, .rate_tick, .timer_tick);
    initial forever #20 clk = ~clk;
    task automatic report_and_stop;
        if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Avalon cycle raised after an edge, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic tick;
        c = 0;
        do begin @(posedge clk); c++; end while (rate_tick !== 1'b1);
    endtask
    function automatic int per(int s, int w, int h, int n);
        return ((s | (w & h)) ? 4 : (w | h) ? 16 : 64) * (n + 1);
    endfunction
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            errors++;
            report_and_stop;
        end
    end
    initial begin
        void'($urandom(32'h3B5CD700));
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        // Reset values, idle status, unmapped places read zero
        for (int i = 0; i < 8; i++) begin
            bus(0, i[2:0], 8'h00);
            chk(q, i == 0 ? 32'h40 : 32'h0);
        end
        // Writable mask and idle status follow the input
        for (int j = 0; j < 2; j++) begin
            receive_idle_flag <= j[0];
            bus(1, 3'h0, j ? 8'h00 : 8'hFF);
            repeat (4) @(posedge clk);
            bus(0, 3'h0, 8'h00);
            chk(q, j ? 32'h40 : 32'h1B);
        end
        // Every mode; sync ignores high speed, 8-bit ignores high byte
        for (int i = 0; i < 8; i++) begin
            hi = $urandom % 2;
            lo = $urandom % 4;
            bus(1, 3'h4, {3'h0, i[2], 1'b0, i[1], 2'h0});
            bus(1, 3'h0, {4'h0, i[0], 3'h0});
            bus(1, 3'h3, hi);
            bus(1, 3'h2, lo);
            p = per(i[2], i[0], i[1], i[0] ? hi * 256 + lo : lo);
            tick;
            chk(c, p);
            tick;
            chk(c, p);
            bus(0, 3'h3, 8'h00);
            chk(q, hi);
        end
        report_and_stop;
    end
endmodule // srbg_rate_gen_tb
`default_nettype wire
